// File: src/efr_router.v
// Functional notes
// [RULE1] Every interrupt-capable peripheral has its own fixed path for masked status.
// [RULE2] A fixed interrupt stays asserted until software clears it at the peripheral.
// [RULE3] DMA trigger: ack of request, request drops, ack drops, then new request.
// [RULE4] Completion sideband from DMA passes back to the peripheral where supported.
// [RULE5] DMA trigger comes only from the condition chosen in the trigger set.
// [RULE6] Channel number fixes the type: single subscriber or two-way splitter.
// [RULE7] Generic event comes only from the condition chosen in the event set.
// [RULE8] Generic event goes onto the channel held in the publisher select.
// [RULE9] A subscriber hears only the channel held in its subscriber select.
// [RULE10] At most one publisher owns a generic channel at a time.
// [RULE11] A single-subscriber channel refuses others until its subscriber leaves.
// [RULE12] A splitter takes two subscribers, then blocks until both have left.
// [RULE13] Four-phase handshake: request, acknowledge, request drop, acknowledge drop.
// [RULE14] One handshake takes four low-power bus clock cycles, one per phase.
// [RULE15] An event raised before the handshake completes is discarded, not queued.
// [RULE16] A subscriber port acts once for every event arriving on its channel.
// [RULE17] A destination is a peripheral, a generic DMA or a generic CPU subscriber.
// [RULE18] The fabric holds no configuration; routing comes from the select inputs.
// [RULE19] A generic CPU interrupt is cleared by the handshake, no status to clear.
// [RULE20] Select value zero means unconnected: no channel, no handshake.
`timescale 1ns/1ps
`include "efr_defs.vh"

module efr_router (
  input wire clk_i,
  input wire srst_i,
  input wire [`EFR_NIRQ-1:0] irq_mis_i,
  output wire [`EFR_NIRQ-1:0] irq_o,
  input wire [`EFR_NDMA*`EFR_NCOND-1:0] dma_cond_i,
  input wire [`EFR_NDMA*`EFR_SELW-1:0] dma_sel_i,
  input wire [`EFR_NDMA-1:0] dma_ack_i,
  input wire [`EFR_NDMA-1:0] dma_done_i,
  output wire [`EFR_NDMA-1:0] dma_req_o,
  output wire [`EFR_NDMA-1:0] dma_done_o,
  input wire [`EFR_NPUB*`EFR_NCOND-1:0] gen_cond_i,
  input wire [`EFR_NPUB*`EFR_SELW-1:0] gen_sel_i,
  input wire [`EFR_NPUB*`EFR_CHW-1:0] pub_chan_i,
  output wire [`EFR_NPUB-1:0] pub_ok_o,
  output wire [`EFR_NPUB-1:0] pub_drop_o,
  input wire [`EFR_NSUB*`EFR_CHW-1:0] sub_chan_i,
  output wire [`EFR_NSUB-1:0] sub_ok_o,
  output wire [`EFR_NSUB-1:0] sub_evt_o,
  output wire [`EFR_NCH-1:0] chan_req_o,
  output wire [`EFR_NCH-1:0] chan_ack_o,
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o
);

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam PH_IDLE = 3'b000;
  localparam PH_REQ = 3'b001;
  localparam PH_ACK = 3'b010;
  localparam PH_DROP = 3'b011;
  localparam PH_DACK = 3'b100;
  localparam DT_IDLE = 2'b00;
  localparam DT_REQ = 2'b01;
  localparam DT_DROP = 2'b10;
  // One bit per trigger route; only routes whose peripheral takes completion carry it.
  localparam [`EFR_NDMA-1:0] DONE_EN = `EFR_DMA_DONE_EN;

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------
  // Picks the internal condition named by a select field.
  function sel_cond;
    input [`EFR_NCOND-1:0] cond;
    input [`EFR_SELW-1:0] sel;
    begin
      sel_cond = cond[sel];
    end
  endfunction

  // Channel field of one port out of a packed select bus.
  function [`EFR_CHW-1:0] ch_at;
    input [`EFR_NPUB*`EFR_CHW-1:0] bus;
    input integer idx;
    begin
      ch_at = bus[idx*`EFR_CHW +: `EFR_CHW];
    end
  endfunction

  // A channel number that names a real channel; zero and overrange do not.
  function ch_ok;
    input [`EFR_CHW-1:0] ch;
    begin
      ch_ok = (ch != `EFR_CH_NONE) && (ch <= `EFR_CH_MAX);
    end
  endfunction

  // Subscriber capacity follows from the channel number alone.
  function [1:0] ch_cap;
    input [`EFR_CHW-1:0] ch;
    begin
      ch_cap = (ch > `EFR_LAST_P2P) ? `EFR_SPLIT_CAP : `EFR_P2P_CAP;
    end
  endfunction

  integer p;
  integer s;
  integer c;
  reg [`EFR_CHW-1:0] ch;
  reg [`EFR_CHW-1:0] sch;

  // --------------------------------------------------------------------------
  // Fixed interrupt and DMA trigger routes
  // --------------------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < `EFR_NIRQ; k = k + 1)
    begin : g_irq
      reg irq_ff;
      // [RULE1] [RULE2] Level follows peripheral status.
      // The level is only forwarded, so it stays until the peripheral clears it.
      always @(posedge clk_i)
      begin
        if (srst_i)
          irq_ff <= 1'b0;
        else
          irq_ff <= irq_mis_i[k];
      end
      assign irq_o[k] = irq_ff;
    end

    for (k = 0; k < `EFR_NDMA; k = k + 1)
    begin : g_dma
      reg [1:0] st_ff;
      reg req_ff;
      reg cond_q_ff;
      reg done_ff;
      wire cond;
      // [RULE5] Selected trigger condition.
      assign cond = sel_cond(dma_cond_i[k*`EFR_NCOND +: `EFR_NCOND], dma_sel_i[k*`EFR_SELW +: `EFR_SELW]);
      // A rising condition while a handshake is open is not remembered; the
      // peripheral would have to raise it again once the route is idle.
      always @(posedge clk_i)
      begin
        if (srst_i)
        begin
          st_ff <= DT_IDLE;
          req_ff <= 1'b0;
          cond_q_ff <= 1'b0;
          done_ff <= 1'b0;
        end
        else
        begin
          cond_q_ff <= cond;
          // [RULE4] Completion sideband pass.
          done_ff <= dma_done_i[k] & DONE_EN[k];
          // [RULE3] Trigger request handshake.
          case (st_ff)
            DT_IDLE:
            begin
              if (cond && !cond_q_ff && !dma_ack_i[k])
              begin
                st_ff <= DT_REQ;
                req_ff <= 1'b1;
              end
            end
            DT_REQ:
            begin
              if (dma_ack_i[k])
              begin
                st_ff <= DT_DROP;
                req_ff <= 1'b0;
              end
            end
            DT_DROP:
            begin
              if (!dma_ack_i[k])
                st_ff <= DT_IDLE;
            end
            default:
            begin
              st_ff <= DT_IDLE;
              req_ff <= 1'b0;
            end
          endcase
        end
      end
      assign dma_req_o[k] = req_ff;
      assign dma_done_o[k] = done_ff;
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Generic channel state
  // --------------------------------------------------------------------------
  reg [`EFR_NPUB-1:0] pub_ok_ff;
  reg [`EFR_NPUB*`EFR_CHW-1:0] pub_ch_ff;
  reg [`EFR_NPUB-1:0] cond_q_ff;
  reg [`EFR_NPUB-1:0] pub_drop_ff;
  reg [`EFR_NSUB-1:0] sub_ok_ff;
  reg [`EFR_NSUB*`EFR_CHW-1:0] sub_ch_ff;
  reg [`EFR_NSUB-1:0] sub_evt_ff;
  reg [`EFR_NCH:1] blk_ff;
  reg [`EFR_NCH:1] req_ff;
  reg [`EFR_NCH:1] ack_ff;
  reg [2:0] ph_ff [1:`EFR_NCH];

  reg [`EFR_NPUB-1:0] nxt_pub_ok;
  reg [`EFR_NPUB*`EFR_CHW-1:0] nxt_pub_ch;
  reg [`EFR_NSUB-1:0] nxt_sub_ok;
  reg [`EFR_NSUB*`EFR_CHW-1:0] nxt_sub_ch;
  reg [`EFR_NCH:1] nxt_blk;
  reg [`EFR_NPUB-1:0] nxt_pub_drop;
  reg [`EFR_NCH:1] taken;
  reg [`EFR_NCH:1] start;
  reg [`EFR_NCH:1] has_sub;
  reg [`EFR_NCH:1] busy;
  reg [1:0] cnt [1:`EFR_NCH];
  reg ev;

  // --------------------------------------------------------------------------
  // Publisher ownership
  // --------------------------------------------------------------------------
  // Owners keep their channel first, so a newcomer can never steal it; among
  // newcomers in one cycle the lowest port index wins.
  always @*
  begin
    nxt_pub_ok = {`EFR_NPUB{1'b0}};
    nxt_pub_ch = {(`EFR_NPUB*`EFR_CHW){1'b0}};
    taken = {`EFR_NCH{1'b0}};
    ch = `EFR_CH_NONE;
    for (p = 0; p < `EFR_NPUB; p = p + 1)
    begin
      ch = ch_at(pub_ch_ff, p);
      if (pub_ok_ff[p] && ch_at(pub_chan_i, p) == ch)
      begin
        nxt_pub_ok[p] = 1'b1;
        nxt_pub_ch[p*`EFR_CHW +: `EFR_CHW] = ch;
        taken[ch] = 1'b1;
      end
    end
    for (p = 0; p < `EFR_NPUB; p = p + 1)
    begin
      ch = ch_at(pub_chan_i, p);
      // [RULE10] [RULE20] Single owner, zero unconnected.
      if (!nxt_pub_ok[p] && ch_ok(ch) && !taken[ch])
      begin
        nxt_pub_ok[p] = 1'b1;
        nxt_pub_ch[p*`EFR_CHW +: `EFR_CHW] = ch;
        taken[ch] = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Subscriber attachment
  // --------------------------------------------------------------------------
  always @*
  begin
    nxt_sub_ok = {`EFR_NSUB{1'b0}};
    nxt_sub_ch = {(`EFR_NSUB*`EFR_CHW){1'b0}};
    nxt_blk = {`EFR_NCH{1'b0}};
    sch = `EFR_CH_NONE;
    for (c = 1; c <= `EFR_NCH; c = c + 1)
      cnt[c] = 2'h0;
    for (s = 0; s < `EFR_NSUB; s = s + 1)
    begin
      sch = ch_at(sub_ch_ff, s);
      if (sub_ok_ff[s] && ch_at(sub_chan_i, s) == sch)
      begin
        nxt_sub_ok[s] = 1'b1;
        nxt_sub_ch[s*`EFR_CHW +: `EFR_CHW] = sch;
        cnt[sch] = cnt[sch] + 2'h1;
      end
    end
    for (s = 0; s < `EFR_NSUB; s = s + 1)
    begin
      sch = ch_at(sub_chan_i, s);
      // [RULE6] [RULE11] [RULE12] Capacity and block.
      if (!nxt_sub_ok[s] && ch_ok(sch) && !blk_ff[sch] && cnt[sch] < ch_cap(sch))
      begin
        nxt_sub_ok[s] = 1'b1;
        nxt_sub_ch[s*`EFR_CHW +: `EFR_CHW] = sch;
        cnt[sch] = cnt[sch] + 2'h1;
      end
    end
    // A full splitter stays shut while any subscriber remains on it.
    for (c = 1; c <= `EFR_NCH; c = c + 1)
      nxt_blk[c] = (blk_ff[c] || cnt[c] == `EFR_SPLIT_CAP) && cnt[c] != 2'h0;
  end

  // --------------------------------------------------------------------------
  // Event capture and discard
  // --------------------------------------------------------------------------
  always @*
  begin
    start = {`EFR_NCH{1'b0}};
    has_sub = {`EFR_NCH{1'b0}};
    busy = {`EFR_NCH{1'b0}};
    nxt_pub_drop = {`EFR_NPUB{1'b0}};
    ev = 1'b0;
    ch = `EFR_CH_NONE;
    for (c = 1; c <= `EFR_NCH; c = c + 1)
      busy[c] = ph_ff[c] != PH_IDLE;
    for (s = 0; s < `EFR_NSUB; s = s + 1)
    begin
      if (sub_ok_ff[s])
        has_sub[ch_at(sub_ch_ff, s)] = 1'b1;
    end
    for (p = 0; p < `EFR_NPUB; p = p + 1)
    begin
      // [RULE7] Selected event condition.
      ev = sel_cond(gen_cond_i[p*`EFR_NCOND +: `EFR_NCOND], gen_sel_i[p*`EFR_SELW +: `EFR_SELW]) & ~cond_q_ff[p];
      ch = ch_at(pub_ch_ff, p);
      // [RULE8] [RULE15] Owned channel, drop when busy.
      if (ev && pub_ok_ff[p])
      begin
        if (!busy[ch] && has_sub[ch])
          start[ch] = 1'b1;
        else
          nxt_pub_drop[p] = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pub_ok_ff <= {`EFR_NPUB{1'b0}};
      pub_ch_ff <= {(`EFR_NPUB*`EFR_CHW){1'b0}};
      cond_q_ff <= {`EFR_NPUB{1'b0}};
      pub_drop_ff <= {`EFR_NPUB{1'b0}};
      sub_ok_ff <= {`EFR_NSUB{1'b0}};
      sub_ch_ff <= {(`EFR_NSUB*`EFR_CHW){1'b0}};
      sub_evt_ff <= {`EFR_NSUB{1'b0}};
      blk_ff <= {`EFR_NCH{1'b0}};
      req_ff <= {`EFR_NCH{1'b0}};
      ack_ff <= {`EFR_NCH{1'b0}};
      for (c = 1; c <= `EFR_NCH; c = c + 1)
        ph_ff[c] <= PH_IDLE;
    end
    else
    begin
      pub_ok_ff <= nxt_pub_ok;
      pub_ch_ff <= nxt_pub_ch;
      sub_ok_ff <= nxt_sub_ok;
      sub_ch_ff <= nxt_sub_ch;
      blk_ff <= nxt_blk;
      pub_drop_ff <= nxt_pub_drop;
      for (p = 0; p < `EFR_NPUB; p = p + 1)
        cond_q_ff[p] <= sel_cond(gen_cond_i[p*`EFR_NCOND +: `EFR_NCOND], gen_sel_i[p*`EFR_SELW +: `EFR_SELW]);
      for (c = 1; c <= `EFR_NCH; c = c + 1)
      begin
        // [RULE13] [RULE14] Four phases, one cycle each.
        case (ph_ff[c])
          PH_IDLE: ph_ff[c] <= start[c] ? PH_REQ : PH_IDLE;
          PH_REQ: ph_ff[c] <= PH_ACK;
          PH_ACK: ph_ff[c] <= PH_DROP;
          PH_DROP: ph_ff[c] <= PH_DACK;
          default: ph_ff[c] <= PH_IDLE;
        endcase
        req_ff[c] <= (ph_ff[c] == PH_IDLE && start[c]) || ph_ff[c] == PH_REQ;
        ack_ff[c] <= ph_ff[c] == PH_REQ || ph_ff[c] == PH_ACK;
      end
      // [RULE9] [RULE16] [RULE17] [RULE19] One pulse per event.
      // The pulse is its own clear, so a CPU or DMA subscriber has no status to reset.
      for (s = 0; s < `EFR_NSUB; s = s + 1)
        sub_evt_ff[s] <= sub_ok_ff[s] && ph_ff[ch_at(sub_ch_ff, s)] == PH_REQ;
    end
  end

  // --------------------------------------------------------------------------
  // Read-only status port
  // --------------------------------------------------------------------------
  // [RULE18] No routing setting is writable here.
  // Writes are accepted and ignored, which keeps the routing in the peripherals.
  always @(posedge clk_i)
  begin
    if (srst_i || !rd_i)
      rdata_o <= `EFR_RD_IDLE;
    else
    begin
      case (addr_i)
        `EFR_OFS_CHAN: rdata_o <= {16'h0000, busy, blk_ff, ack_ff, req_ff};
        `EFR_OFS_PUB: rdata_o <= {28'h0000000, pub_ok_ff};
        `EFR_OFS_SUB: rdata_o <= {28'h0000000, sub_ok_ff};
        default: rdata_o <= `EFR_RD_IDLE;
      endcase
    end
  end

  assign pub_ok_o = pub_ok_ff;
  assign pub_drop_o = pub_drop_ff;
  assign sub_ok_o = sub_ok_ff;
  assign sub_evt_o = sub_evt_ff;
  assign chan_req_o = req_ff;
  assign chan_ack_o = ack_ff;

endmodule

// File: src/efr_defs.vh
`ifndef EFR_DEFS_VH
`define EFR_DEFS_VH

// ----------------------------------------------------------------------------
// Fabric dimensions
// ----------------------------------------------------------------------------
`define EFR_NPUB 4
`define EFR_NSUB 4
`define EFR_NCH 4
`define EFR_CHW 3
`define EFR_NIRQ 4
`define EFR_NDMA 2
`define EFR_NCOND 4
`define EFR_SELW 2

// ----------------------------------------------------------------------------
// Channel numbering and types
// ----------------------------------------------------------------------------
`define EFR_CH_NONE 3'h0
`define EFR_CH_MAX 3'h4
`define EFR_LAST_P2P 3'h2
`define EFR_SPLIT_CAP 2'h2
`define EFR_P2P_CAP 2'h1

// ----------------------------------------------------------------------------
// DMA completion sideband present per trigger route
// ----------------------------------------------------------------------------
`define EFR_DMA_DONE_EN 2'h1

// ----------------------------------------------------------------------------
// Status port word offsets and idle read value
// ----------------------------------------------------------------------------
`define EFR_OFS_CHAN 4'h0
`define EFR_OFS_PUB 4'h4
`define EFR_OFS_SUB 4'h8
`define EFR_RD_IDLE 32'h00000000

`endif

// File: test/efr_router_chk.sv
`timescale 1ns/1ps
// ----
// Port checker for the event fabric
// ----
module efr_router_chk (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [3:0] irq_mis_i,
  input wire logic [3:0] irq_o,
  input wire logic [1:0] dma_ack_i,
  input wire logic [1:0] dma_done_i,
  input wire logic [1:0] dma_req_o,
  input wire logic [1:0] dma_done_o,
  input wire logic [11:0] pub_chan_i,
  input wire logic [3:0] pub_ok_o,
  input wire logic [3:0] pub_drop_o,
  input wire logic [3:0] sub_ok_o,
  input wire logic [3:0] sub_evt_o,
  input wire logic [3:0] chan_req_o,
  input wire logic [3:0] chan_ack_o
);
  // One clock domain, so clock and reset are given once here.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // The first edge after reset sees history from inside the reset, so it is skipped.
  property p_irq; !$past(srst_i) |-> irq_o == $past(irq_mis_i); endproperty
  a_irq: assert property (p_irq) else $error("irq path mismatch");
  property p_dma_drop; dma_req_o[0] && dma_ack_i[0] |=> !dma_req_o[0]; endproperty
  a_dma_drop: assert property (p_dma_drop) else $error("dma request kept after ack");
  property p_dma_hold; !dma_req_o[0] && dma_ack_i[0] |=> !dma_req_o[0]; endproperty
  a_dma_hold: assert property (p_dma_hold) else $error("dma request before ack drop");
  property p_done; !$past(srst_i) |-> dma_done_o == {1'b0, $past(dma_done_i[0])}; endproperty
  a_done: assert property (p_done) else $error("completion sideband wrong");
  // Four phases, one cycle each, on a single-subscriber channel.
  property p_hs;
    $rose(chan_req_o[0]) |-> !chan_ack_o[0] ##1 chan_req_o[0] && chan_ack_o[0]
      ##1 !chan_req_o[0] && chan_ack_o[0] ##1 !chan_req_o[0] && !chan_ack_o[0];
  endproperty
  a_hs: assert property (p_hs) else $error("handshake phase wrong");
  property p_gap; $fell(chan_ack_o[0]) && !$past(srst_i) |-> !chan_req_o[0] ##1 !chan_req_o[0]; endproperty
  a_gap: assert property (p_gap) else $error("channel restarted too early");
  property p_evt; sub_evt_o[0] |-> sub_ok_o[0] && |(chan_req_o & chan_ack_o); endproperty
  a_evt: assert property (p_evt) else $error("event outside ack phase");
  property p_own; pub_ok_o[0] && pub_ok_o[1] |-> $past(pub_chan_i[2:0]) != $past(pub_chan_i[5:3]); endproperty
  a_own: assert property (p_own) else $error("two owners of one channel");
  c_hs: cover property ($rose(chan_req_o[0]));
  c_drop: cover property (pub_drop_o[0]);
  c_done: cover property (dma_done_o[0]);
endmodule

bind efr_router efr_router_chk u_chk (.clk_i(clk_i), .srst_i(srst_i), .irq_mis_i(irq_mis_i), .irq_o(irq_o),
  .dma_ack_i(dma_ack_i), .dma_done_i(dma_done_i), .dma_req_o(dma_req_o), .dma_done_o(dma_done_o),
  .pub_chan_i(pub_chan_i), .pub_ok_o(pub_ok_o), .pub_drop_o(pub_drop_o), .sub_ok_o(sub_ok_o),
  .sub_evt_o(sub_evt_o), .chan_req_o(chan_req_o), .chan_ack_o(chan_ack_o));

// File: test/efr_dma_model.sv
`timescale 1ns/1ps
// ----
// DMA controller stand-in for one trigger route
// ----
module efr_dma_model #(
  parameter int N_XFER = 3
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic req_i,
  input wire logic slow_i,
  output logic ack_o,
  output logic done_o
);
  logic [1:0] dly_ff;
  logic [3:0] cnt_ff;
  // Slow mode keeps the request waiting, as busy arbitration would.
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ack_o <= 1'b0;
      done_o <= 1'b0;
      dly_ff <= 2'h0;
      cnt_ff <= 4'h0;
    end
    else
    begin
      done_o <= 1'b0;
      if (req_i && !ack_o)
      begin
        dly_ff <= dly_ff + 2'h1;
        ack_o <= !slow_i || dly_ff == 2'h3;
      end
      else if (!req_i && ack_o)
      begin
        ack_o <= 1'b0;
        dly_ff <= 2'h0;
        cnt_ff <= (cnt_ff == N_XFER - 1) ? 4'h0 : cnt_ff + 4'h1;
        done_o <= cnt_ff == N_XFER - 1;
      end
    end
  end
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, slow = 1'b0, rq_q = 1'b0, dr;
  logic [3:0] irq_mis_i = 4'h0, dma_sel_i = 4'h6, addr_i = 4'h0;
  logic [7:0] dma_cond_i = 8'h00, gen_sel_i = 8'h00;
  logic [15:0] gen_cond_i = 16'h0000;
  logic [11:0] pub_chan_i = 12'h000, sub_chan_i = 12'h000;
  logic [31:0] wdata_i = 32'h00000000;
  logic [1:0] dn = 2'h0, ev;
  wire [1:0] dma_ack, dma_dm, dma_req_o, dma_done_o;
  wire [3:0] irq_o, pub_ok_o, pub_drop_o, sub_ok_o, sub_evt_o, chan_req_o, chan_ack_o;
  wire [31:0] rdata_o;
  int n_errors = 0, compares = 0, nrq = 0, ne0;
  // Rows: publisher channel, subscriber 1 and 0 channels, expected events, expected drop.
  logic [11:0] rows [7] = '{{3'h1, 3'h0, 3'h1, 2'h1, 1'h0}, {3'h1, 3'h0, 3'h2, 2'h0, 1'h1},
    {3'h2, 3'h0, 3'h2, 2'h1, 1'h0}, {3'h3, 3'h3, 3'h3, 2'h3, 1'h0}, {3'h4, 3'h4, 3'h0, 2'h2, 1'h0},
    {3'h0, 3'h0, 3'h1, 2'h0, 1'h0}, {3'h5, 3'h0, 3'h5, 2'h0, 1'h0}};

  efr_router dut (.clk_i(clk_i), .srst_i(srst_i), .irq_mis_i(irq_mis_i), .irq_o(irq_o),
    .dma_cond_i(dma_cond_i), .dma_sel_i(dma_sel_i), .dma_ack_i(dma_ack), .dma_done_i(dma_dm),
    .dma_req_o(dma_req_o), .dma_done_o(dma_done_o), .gen_cond_i(gen_cond_i), .gen_sel_i(gen_sel_i),
    .pub_chan_i(pub_chan_i), .pub_ok_o(pub_ok_o), .pub_drop_o(pub_drop_o), .sub_chan_i(sub_chan_i),
    .sub_ok_o(sub_ok_o), .sub_evt_o(sub_evt_o), .chan_req_o(chan_req_o), .chan_ack_o(chan_ack_o),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
  efr_dma_model m0 (.clk_i(clk_i), .srst_i(srst_i), .req_i(dma_req_o[0]), .slow_i(slow),
    .ack_o(dma_ack[0]), .done_o(dma_dm[0]));
  efr_dma_model m1 (.clk_i(clk_i), .srst_i(srst_i), .req_i(dma_req_o[1]), .slow_i(slow),
    .ack_o(dma_ack[1]), .done_o(dma_dm[1]));

  // Free-running 40 MHz clock.
  initial forever #12.5 clk_i = ~clk_i;

  // Counts new trigger requests on route 0 and latches any completion seen.
  always @(posedge clk_i)
  begin
    rq_q <= dma_req_o[0];
    nrq <= nrq + (dma_req_o[0] && !rq_q);
    dn <= dn | dma_done_o;
  end

  // Outputs are sampled 1 ns after the edge so the design's updates have landed.
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic watch(input int n);
    ev = 2'h0;
    dr = 1'b0;
    ne0 = 0;
    repeat (n)
    begin
      tick();
      ev = ev | sub_evt_o[1:0];
      dr = dr | pub_drop_o[0];
      ne0 += sub_evt_o[0];
    end
  endtask
  // The trailing tick keeps two reads from touching the strobe in one time step.
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    tick();
    rd_i <= 1'b0;
    chk(rdata_o, e);
    tick();
  endtask
  task automatic report_and_stop();
    $display("n_errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence: reset, table of routes, then the hand-written cases.
  initial
  begin
    tick(3);
    srst_i <= 1'b0;
    tick();
    chk({dma_req_o, pub_ok_o, sub_ok_o, chan_req_o}, 0);
    foreach (rows[i])
    begin
      pub_chan_i[2:0] <= rows[i][11:9];
      sub_chan_i[5:0] <= rows[i][8:3];
      tick(2);
      gen_cond_i[0] <= 1'b1;
      watch(7);
      chk(ev, rows[i][2:1]);
      if (rows[i][11:9] inside {[1:4]})
        chk(dr, rows[i][0]);
      gen_cond_i[0] <= 1'b0;
      pub_chan_i[2:0] <= 3'h0;
      sub_chan_i[5:0] <= 6'h00;
      tick(2);
    end
    irq_mis_i <= 4'hA;
    tick();
    chk(irq_o, 4'hA);
    tick(4);
    chk(irq_o, 4'hA);
    irq_mis_i <= 4'h0;
    tick();
    chk(irq_o, 4'h0);
    dma_cond_i <= 8'h42;
    tick(3);
    chk(dma_req_o, 2'h0);
    dma_cond_i <= 8'h00;
    tick();
    // Rises every third cycle: those inside a handshake must be lost.
    repeat (4)
    begin
      dma_cond_i <= 8'h24;
      tick();
      dma_cond_i <= 8'h00;
      tick(2);
    end
    tick(4);
    chk(nrq, 2);
    slow <= 1'b1;
    dma_cond_i <= 8'h24;
    tick();
    dma_cond_i <= 8'h00;
    tick(16);
    chk(nrq, 3);
    chk(dn, 2'h1);
    pub_chan_i <= 12'h001;
    sub_chan_i <= 12'h001;
    tick(2);
    gen_cond_i[1] <= 1'b1;
    watch(6);
    chk(ev, 2'h0);
    gen_cond_i <= 16'h0001;
    tick();
    gen_cond_i[0] <= 1'b0;
    tick();
    // The first event is delivered two edges after its rise, before the watch window opens.
    chk(sub_evt_o[0], 1'b1);
    gen_cond_i[0] <= 1'b1;
    watch(8);
    // The second rise lands inside the open handshake: dropped, and nothing queued after it.
    chk({ne0[1:0], dr}, 3'h1);
    pub_chan_i <= 12'h009;
    sub_chan_i <= 12'h009;
    tick(2);
    chk({pub_ok_o, sub_ok_o}, 8'h11);
    addr_i <= 4'h4;
    wdata_i <= 32'hFFFFFFFF;
    wr_i <= 1'b1;
    tick();
    wr_i <= 1'b0;
    tick();
    rd(4'h4, 32'h00000001);
    rd(4'h8, 32'h00000001);
    rd(4'h0, 32'h00000000);
    rd(4'hC, 32'h00000000);
    pub_chan_i <= 12'h011;
    sub_chan_i <= 12'h01B;
    tick(2);
    sub_chan_i[8:6] <= 3'h3;
    tick(2);
    chk(sub_ok_o, 4'h3);
    sub_chan_i[2:0] <= 3'h0;
    tick(2);
    chk(sub_ok_o, 4'h2);
    sub_chan_i[5:3] <= 3'h0;
    tick(4);
    chk(sub_ok_o, 4'h4);
    report_and_stop();
  end

  // The sequence needs under 300 cycles; ten times that means a hang.
  initial
  begin
    repeat (3000) @(posedge clk_i);
    n_errors++;
    report_and_stop();
  end
endmodule
